// file: design/cpc_params.svh
// constants for the conversion clock and power control block
`ifndef CPC_PARAMS_SVH
`define CPC_PARAMS_SVH

// ----------------------------------------------------------------
// clocking and conversion timing
// ----------------------------------------------------------------
`define CPC_CLK_KHZ         100000
`define CPC_RING_MIN_KHZ    3600
// longest oscillator period in system cycles, rounded down
`define CPC_RING_PERIOD_CYC (`CPC_CLK_KHZ / `CPC_RING_MIN_KHZ)
`define CPC_CONV_CLOCKS     14
`define CPC_CONV_LAST       4'hd

// ----------------------------------------------------------------
// command words
// ----------------------------------------------------------------
`define CPC_SW_PD_CMD       16'h8000

// ----------------------------------------------------------------
// configuration register fields and reset value
// ----------------------------------------------------------------
`define CPC_CFG_WIDTH       12
`define CPC_CFG_RESET       12'h000
`define CPC_CFG_REF_EXT     11
`define CPC_CFG_REF_4V      10
`define CPC_CFG_CLK_SCLK    9
`define CPC_CFG_DIV_HI      8
`define CPC_CFG_DIV_LO      7
`define CPC_CFG_FMT_TWOS    6

// ----------------------------------------------------------------
// pin synchroniser bit positions and idle levels
// ----------------------------------------------------------------
`define CPC_PIN_SCLK        0
`define CPC_PIN_CS_N        1
`define CPC_PIN_FRAME       2
`define CPC_PIN_START_N     3
`define CPC_PIN_PD_N        4
`define CPC_PIN_IDLE        5'h1a

// ----------------------------------------------------------------
// result codes
// ----------------------------------------------------------------
`define CPC_CODE_FULL       12'hfff
`define CPC_CODE_ZERO       12'h000

`endif

// file: design/cpc_pkg.sv
// types shared by the conversion clock and power control block
`default_nettype none

package cpc_pkg;

   // ----------------------------------------------------------------
   // power and conversion states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      cpc_st_active  = 3'b000,
      cpc_st_convert = 3'b001,
      cpc_st_auto_pd = 3'b010,
      cpc_st_sw_pd   = 3'b011,
      cpc_st_hw_pd   = 3'b100
   } cpc_state_t;

   // ----------------------------------------------------------------
   // serial clock divide ratio encoding
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      cpc_div_by1 = 2'b00,
      cpc_div_by2 = 2'b01,
      cpc_div_by4 = 2'b10
   } cpc_div_t;

endpackage : cpc_pkg

`default_nettype wire

// file: design/cpc_conv_clock.sv
// conversion clock strobe from internal oscillator or divided serial clock
`include "cpc_params.svh"
`default_nettype none

module cpc_conv_clock (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // source control
   input  wire logic       run,
   input  wire logic       use_sclk,
   input  wire logic [1:0] div_sel,
   input  wire logic       sclk_rise,
   // conversion clock strobe
   output logic            conv_tick
);

   localparam logic [4:0] ring_last = 5'(`CPC_RING_PERIOD_CYC - 1);

   logic [4:0] ring_count;
   logic [1:0] div_count;
   logic [1:0] div_last;
   logic       ring_tick;
   logic       sclk_tick;

   // last count of the divider for a ratio of 1, 2 or 4
   function automatic logic [1:0] div_last_of(input logic [1:0] sel);
      case (cpc_pkg::cpc_div_t'(sel))
         cpc_pkg::cpc_div_by2: div_last_of = 2'h1;
         cpc_pkg::cpc_div_by4: div_last_of = 2'h3;
         default:              div_last_of = 2'h0;
      endcase
   endfunction : div_last_of

   // ----------------------------------------------------------------
   // strobe selection
   // ----------------------------------------------------------------
   assign div_last  = div_last_of(div_sel);
   assign ring_tick = run && !use_sclk && ring_count == ring_last;
   assign sclk_tick = run && use_sclk && sclk_rise
                      && div_count == div_last;
   assign conv_tick = ring_tick || sclk_tick;

   // internal oscillator period counter
   always_ff @(posedge clock)
   begin
      if (reset || !run || use_sclk || ring_tick)
         ring_count <= 5'h00;
      else
         ring_count <= ring_count + 5'h01;
   end

   // serial clock edge divider
   always_ff @(posedge clock)
   begin
      if (reset || !run)
         div_count <= 2'h0;
      else if (use_sclk && sclk_rise)
         div_count <= (div_count == div_last) ? 2'h0
                                              : div_count + 2'h1;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [5:0] gap;
   logic [2:0] rises;

   always_ff @(posedge clock)
   begin
      if (reset || !run || use_sclk || conv_tick)
         gap <= 6'h00;
      else
         gap <= gap + 6'h01;
   end

   always_ff @(posedge clock)
   begin
      if (reset || !run || !use_sclk || conv_tick)
         rises <= 3'h0;
      else if (sclk_rise)
         rises <= rises + 3'h1;
   end

   property p_ring_rate;
      @(posedge clock) disable iff (reset)
      (run && !use_sclk)
         |-> (gap < 6'd27) && (conv_tick == (gap == 6'd26));
   endproperty
   a_ring_rate: assert property (p_ring_rate)
      else $error("oscillator strobe slower than allowed");

   property p_sclk_div;
      @(posedge clock) disable iff (reset)
      (run && use_sclk && sclk_rise && $past(run) && $stable(div_sel))
         |-> conv_tick == (rises == {1'b0, div_last_of(div_sel)});
   endproperty
   a_sclk_div: assert property (p_sclk_div)
      else $error("serial clock divide ratio wrong");

endmodule : cpc_conv_clock

`default_nettype wire

// file: design/cpc_power_control.sv
// conversion clock selection, conversion timing and power-down control
`include "cpc_params.svh"
`default_nettype none

// Contract
// - each conversion takes exactly fourteen conversion clocks, then ends.
// - conversion clock is oscillator or serial clock divided by 1, 2, 4.
// - internal oscillator strobe runs at 3.6 MHz or faster.
// - after each conversion enter automatic low power, reference kept on.
// - chip select, frame sync or start wakes automatic low power fast.
// - command word 8000h enters software power-down, reference off.
// - hardware power-down pin powers everything down at once.
// - releasing hardware power-down pin resumes operation.
// - access restores from software power-down with no added delay.
// - power-down never changes the configuration register.
// - leaving power-down restarts the channel sweep from its start.
// - entering software or hardware power-down empties the result FIFO.
// - reference internal or external; internal level 2 V or 4 V.
// - binary results clamp to all ones and all zeros at references.
module cpc_power_control (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // device pins
   input  wire logic        sclk_pin,
   input  wire logic        chip_select_n,
   input  wire logic        frame_sync_input,
   input  wire logic        conversion_start_pin_n,
   input  wire logic        hardware_powerdown_pin_n,
   // decoded commands from the serial port
   input  wire logic        cmd_valid,
   input  wire logic [15:0] cmd_word,
   input  wire logic        cfg_write,
   input  wire logic [11:0] cfg_data,
   input  wire logic        conv_request,
   // analog front end, in code units
   input  wire logic [13:0] sample_code,
   input  wire logic [13:0] upper_reference_code,
   input  wire logic [13:0] lower_reference_code,
   // configuration and results
   output logic [11:0]      configuration_register,
   output logic             conv_busy,
   output logic             conv_done,
   output logic [11:0]      result_code,
   // power and reference control
   output logic             analog_power_on,
   output logic             reference_power_on,
   output logic             reference_internal,
   output logic             reference_4v,
   output logic             powered_down,
   output logic             fifo_flush,
   output logic             sweep_restart
);

   cpc_pkg::cpc_state_t state;
   cpc_pkg::cpc_state_t next_state;

   logic [4:0]  pin_meta;
   logic [4:0]  pin_sync;
   logic        sclk_last;
   logic        sclk_rise;
   logic        access;
   logic        pd_pin;
   logic        sw_cmd;
   logic        conv_tick;
   logic [3:0]  tick_count;
   logic        last_tick;
   logic        start_conv;
   logic [13:0] held_sample;
   logic [13:0] diff;
   logic        above;
   logic        below;
   logic [11:0] bin_code;
   logic [11:0] out_code;

   // full power-down states, reference off
   function automatic logic is_full_pd(input cpc_pkg::cpc_state_t st);
      return st == cpc_pkg::cpc_st_sw_pd || st == cpc_pkg::cpc_st_hw_pd;
   endfunction : is_full_pd

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // two flops on every pin, third flop for the serial clock edge
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         pin_meta  <= `CPC_PIN_IDLE;
         pin_sync  <= `CPC_PIN_IDLE;
         sclk_last <= 1'b0;
      end
      else
      begin
         pin_meta  <= {hardware_powerdown_pin_n, conversion_start_pin_n,
                       frame_sync_input, chip_select_n, sclk_pin};
         pin_sync  <= pin_meta;
         sclk_last <= pin_sync[`CPC_PIN_SCLK];
      end
   end

   // decoded pin events and commands
   assign sclk_rise = pin_sync[`CPC_PIN_SCLK] && !sclk_last;
   assign access    = !pin_sync[`CPC_PIN_CS_N] || pin_sync[`CPC_PIN_FRAME]
                      || !pin_sync[`CPC_PIN_START_N];
   assign pd_pin    = !pin_sync[`CPC_PIN_PD_N];
   assign sw_cmd    = cmd_valid && cmd_word == `CPC_SW_PD_CMD;

   // ----------------------------------------------------------------
   // power state machine
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      if (pd_pin)
         next_state = cpc_pkg::cpc_st_hw_pd;
      else if (sw_cmd)
         next_state = cpc_pkg::cpc_st_sw_pd;
      else
      begin
         case (state)
            cpc_pkg::cpc_st_hw_pd:
               next_state = cpc_pkg::cpc_st_active;
            cpc_pkg::cpc_st_sw_pd:
               if (access)
                  next_state = cpc_pkg::cpc_st_active;
            cpc_pkg::cpc_st_auto_pd:
               if (conv_request)
                  next_state = cpc_pkg::cpc_st_convert;
               else if (access)
                  next_state = cpc_pkg::cpc_st_active;
            cpc_pkg::cpc_st_active:
               if (conv_request)
                  next_state = cpc_pkg::cpc_st_convert;
            cpc_pkg::cpc_st_convert:
               if (last_tick)
                  next_state = cpc_pkg::cpc_st_auto_pd;
            default:
               next_state = cpc_pkg::cpc_st_active;
         endcase
      end
   end

   // state register
   always_ff @(posedge clock)
   begin
      if (reset)
         state <= cpc_pkg::cpc_st_active;
      else
         state <= next_state;
   end

   // flush on entry to full power-down, sweep restart on exit
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         fifo_flush    <= 1'b0;
         sweep_restart <= 1'b0;
      end
      else
      begin
         fifo_flush    <= is_full_pd(next_state) && !is_full_pd(state);
         sweep_restart <= is_full_pd(state) && !is_full_pd(next_state);
      end
   end

   // ----------------------------------------------------------------
   // conversion timing
   // ----------------------------------------------------------------
   cpc_conv_clock u_conv_clock (
      .clock     (clock),
      .reset     (reset),
      .run       (state == cpc_pkg::cpc_st_convert),
      .use_sclk  (configuration_register[`CPC_CFG_CLK_SCLK]),
      .div_sel   (configuration_register[`CPC_CFG_DIV_HI:`CPC_CFG_DIV_LO]),
      .sclk_rise (sclk_rise),
      .conv_tick (conv_tick)
   );

   assign start_conv = next_state == cpc_pkg::cpc_st_convert
                       && state != cpc_pkg::cpc_st_convert;
   assign last_tick  = state == cpc_pkg::cpc_st_convert && conv_tick
                       && tick_count == `CPC_CONV_LAST;

   // conversion clock counter
   always_ff @(posedge clock)
   begin
      if (reset || start_conv)
         tick_count <= 4'h0;
      else if (state == cpc_pkg::cpc_st_convert && conv_tick)
         tick_count <= tick_count + 4'h1;
   end

   // ----------------------------------------------------------------
   // result coding
   // ----------------------------------------------------------------
   assign above    = held_sample >= upper_reference_code;
   assign below    = held_sample <= lower_reference_code;
   assign diff     = held_sample - lower_reference_code;
   assign bin_code = above ? `CPC_CODE_FULL :
                     below ? `CPC_CODE_ZERO :
                     (diff > 14'h0fff) ? `CPC_CODE_FULL : diff[11:0];
   assign out_code = configuration_register[`CPC_CFG_FMT_TWOS]
                     ? {~bin_code[11], bin_code[10:0]} : bin_code;

   // sample hold, result and done strobe
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         held_sample <= 14'h0000;
         result_code <= `CPC_CODE_ZERO;
         conv_done   <= 1'b0;
      end
      else
      begin
         if (start_conv)
            held_sample <= sample_code;
         if (last_tick && next_state == cpc_pkg::cpc_st_auto_pd)
            result_code <= out_code;
         conv_done <= last_tick && next_state == cpc_pkg::cpc_st_auto_pd;
      end
   end

   // ----------------------------------------------------------------
   // configuration register
   // ----------------------------------------------------------------
   // writes only while powered; power-down leaves contents alone
   always_ff @(posedge clock)
   begin
      if (reset)
         configuration_register <= `CPC_CFG_RESET;
      else if (cfg_write && !is_full_pd(state) && !pd_pin)
         configuration_register <= cfg_data;
   end

   // ----------------------------------------------------------------
   // power and reference outputs
   // ----------------------------------------------------------------
   // raw pin gates power so hardware power-down acts without a clock
   assign analog_power_on    = hardware_powerdown_pin_n
                               && (state == cpc_pkg::cpc_st_active
                               || state == cpc_pkg::cpc_st_convert);
   assign reference_power_on = hardware_powerdown_pin_n
                               && !is_full_pd(state);
   assign reference_internal = !configuration_register[`CPC_CFG_REF_EXT];
   assign reference_4v       = configuration_register[`CPC_CFG_REF_4V];
   assign powered_down       = is_full_pd(state);
   assign conv_busy          = state == cpc_pkg::cpc_st_convert;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   logic [3:0] seen_ticks;
   logic       raw_access;

   assign raw_access = !chip_select_n || frame_sync_input
                       || !conversion_start_pin_n;

   always_ff @(posedge clock)
   begin
      if (reset || start_conv)
         seen_ticks <= 4'h0;
      else if (conv_busy && conv_tick)
         seen_ticks <= seen_ticks + 4'h1;
   end

   property p_conv_len;
      conv_done |-> seen_ticks == 4'd14;
   endproperty
   a_conv_len: assert property (p_conv_len)
      else $error("conversion did not take fourteen clocks");

   property p_auto_pd;
      conv_done && hardware_powerdown_pin_n
         |-> state == cpc_pkg::cpc_st_auto_pd && reference_power_on
             && !analog_power_on;
   endproperty
   a_auto_pd: assert property (p_auto_pd)
      else $error("no automatic low power after conversion");

   sequence s_held_access;
      (raw_access && hardware_powerdown_pin_n && !cmd_valid)[*3];
   endsequence
   property p_wake;
      (state == cpc_pkg::cpc_st_auto_pd ##0 s_held_access)
         |=> state != cpc_pkg::cpc_st_auto_pd;
   endproperty
   a_wake: assert property (p_wake)
      else $error("access did not wake from low power");

   property p_sw_pd;
      sw_cmd && !pd_pin |=> state == cpc_pkg::cpc_st_sw_pd
                            && !reference_power_on ##1 !conv_busy;
   endproperty
   a_sw_pd: assert property (p_sw_pd)
      else $error("power-down command not obeyed");

   property p_hw_pd;
      !hardware_powerdown_pin_n
         |-> !reference_power_on && !analog_power_on
             ##3 state == cpc_pkg::cpc_st_hw_pd;
   endproperty
   a_hw_pd: assert property (p_hw_pd)
      else $error("hardware power-down not immediate");

   property p_hw_exit;
      state == cpc_pkg::cpc_st_hw_pd && !pd_pin && !sw_cmd
         |=> state == cpc_pkg::cpc_st_active ##0 sweep_restart;
   endproperty
   a_hw_exit: assert property (p_hw_exit)
      else $error("no resume after power-down pin release");

   property p_sw_exit;
      state == cpc_pkg::cpc_st_sw_pd && access && !pd_pin && !sw_cmd
         |=> state == cpc_pkg::cpc_st_active;
   endproperty
   a_sw_exit: assert property (p_sw_exit)
      else $error("access did not restore from power-down");

   property p_cfg_kept;
      (powered_down || pd_pin) |=> $stable(configuration_register);
   endproperty
   a_cfg_kept: assert property (p_cfg_kept)
      else $error("configuration changed in power-down");

   property p_sweep;
      $fell(powered_down) |-> sweep_restart;
   endproperty
   a_sweep: assert property (p_sweep)
      else $error("sweep not restarted on wake");

   property p_flush;
      $rose(powered_down) |-> fifo_flush ##1 !fifo_flush;
   endproperty
   a_flush: assert property (p_flush)
      else $error("FIFO not emptied on power-down");

   property p_clamp;
      conv_done && !configuration_register[`CPC_CFG_FMT_TWOS]
         |-> (held_sample >= upper_reference_code
              ? result_code == `CPC_CODE_FULL : 1'b1)
          && (held_sample <= lower_reference_code
              && held_sample < upper_reference_code
              ? result_code == `CPC_CODE_ZERO : 1'b1);
   endproperty
   a_clamp: assert property (p_clamp)
      else $error("result not clamped at reference");

endmodule : cpc_power_control

`default_nettype wire

// file: tb/cpc_host_model.sv
// host side model: serial clock and control pins of the converter
`default_nettype none

module cpc_host_model #(
   parameter int SCLK_HALF  = 10, // 5 MHz serial clock at 100 MHz
   parameter int WARMUP_CYC = 50  // shortened reference warm-up
) (
   // clock
   input  wire logic clock,
   // device pins
   output var logic  sclk_pin,
   output var logic  chip_select_n,
   output var logic  frame_sync_input,
   output var logic  conversion_start_pin_n,
   output var logic  hardware_powerdown_pin_n
);
   timeunit 1ns;
   timeprecision 1ps;

   // --------------------
   // pin drivers
   // --------------------
   // pins idle, serial clock still outside frames
   initial
   begin
      sclk_pin                 = 1'b0;
      chip_select_n            = 1'b1;
      frame_sync_input         = 1'b0;
      conversion_start_pin_n   = 1'b1;
      hardware_powerdown_pin_n = 1'b1;
   end

   // one access pin on or off: 0 select, 1 frame sync, 2 start
   task automatic access(input int k, input bit on);
      case (k)
         0: chip_select_n = !on;
         1: frame_sync_input = on;
         default: conversion_start_pin_n = !on;
      endcase
   endtask : access

   // power-down pin; high releases the device
   task automatic set_pd_pin(input bit v);
      hardware_powerdown_pin_n = v;
   endtask : set_pd_pin

   // wait out reference warm-up before new conversions
   task automatic warm_up();
      repeat (WARMUP_CYC) @(negedge clock);
   endtask : warm_up

   // a frame of serial clock rises, 5 MHz keeps div 1 under 6 MHz
   task automatic frame(input int rises);
      repeat (rises)
      begin
         repeat (SCLK_HALF) @(negedge clock);
         sclk_pin <= 1'b1;
         repeat (SCLK_HALF) @(negedge clock);
         sclk_pin <= 1'b0;
      end
   endtask : frame
endmodule : cpc_host_model

`default_nettype wire

// file: tb/conversion_clock_power_control_tb.sv
// testbench for the conversion clock and power control block
`include "cpc_params.svh"
`default_nettype none

`define CHK(nm, e, g) \
   begin \
      compares++; \
      if ((g) !== (e)) \
      begin \
         n_errors++; \
         $display("[FAIL] %s expected %h seen %h", nm, e, g); \
      end \
   end

module conversion_clock_power_control_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // --------------------
   // signals
   // --------------------
   logic clock = 1'b0, reset = 1'b1, cmd_valid = 1'b0, cfg_write = 1'b0;
   logic conv_request = 1'b0;
   logic [15:0] cmd_word = 16'h0000;
   logic [11:0] cfg_data = 12'h000, configuration_register, result_code;
   logic [13:0] sample_code = 14'h0000;
   logic [13:0] upper_code = 14'h0900, lower_code = 14'h0100;
   logic sclk_pin, cs_n, frame_sync, start_n, pd_n, conv_busy, conv_done;
   logic ana_on, ref_on, ref_int, ref_4v, powered_down, fifo_flush;
   logic sweep_restart;
   int n_errors = 0, compares = 0, cycles = 0;
   int cyc, rises;
   bit f, r;
   cpc_pkg::cpc_div_t enc;

   always #5 clock = !clock;

   cpc_host_model u_cpc_host_model (.clock(clock), .sclk_pin(sclk_pin),
      .chip_select_n(cs_n), .frame_sync_input(frame_sync),
      .conversion_start_pin_n(start_n),
      .hardware_powerdown_pin_n(pd_n));

   cpc_power_control u_cpc_power_control (.clock(clock), .reset(reset),
      .sclk_pin(sclk_pin), .chip_select_n(cs_n),
      .frame_sync_input(frame_sync),
      .conversion_start_pin_n(start_n), .hardware_powerdown_pin_n(pd_n),
      .cmd_valid(cmd_valid), .cmd_word(cmd_word), .cfg_write(cfg_write),
      .cfg_data(cfg_data), .conv_request(conv_request),
      .sample_code(sample_code), .upper_reference_code(upper_code),
      .lower_reference_code(lower_code),
      .configuration_register(configuration_register),
      .conv_busy(conv_busy), .conv_done(conv_done),
      .result_code(result_code), .analog_power_on(ana_on),
      .reference_power_on(ref_on), .reference_internal(ref_int),
      .reference_4v(ref_4v), .powered_down(powered_down),
      .fifo_flush(fifo_flush), .sweep_restart(sweep_restart));

   // --------------------
   // tasks
   // --------------------
   task automatic give_verdict();
      if (n_errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict

   // hang guard
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         give_verdict();
      end
   end

   task automatic wcfg(input logic [11:0] v);
      cfg_data = v;
      cfg_write = 1'b1;
      @(negedge clock);
      cfg_write = 1'b0;
      @(negedge clock);
   endtask : wcfg

   task automatic cmd(input logic [15:0] w);
      cmd_word = w;
      cmd_valid = 1'b1;
      @(negedge clock);
      cmd_valid = 1'b0;
   endtask : cmd

   // one conversion; div 0 is the oscillator, else frames of serial clock
   task automatic conv(input int div);
      bit pr;
      pr = sclk_pin;
      rises = 0;
      conv_request = 1'b1;
      for (cyc = 0; cyc < 2000; cyc++)
      begin
         @(negedge clock);
         conv_request = 1'b0;
         if (cyc == 1 && div > 0)
            fork
               u_cpc_host_model.frame(14 * div + 1);
            join_none
         if (sclk_pin && !pr)
            rises++;
         pr = sclk_pin;
         if (conv_done === 1'b1)
            break;
      end
      `CHK("power after conv", 2'b01, {ana_on, ref_on})
      wait fork;
   endtask : conv

   // look for flush and restart pulses over n cycles
   task automatic watch(input int n);
      f = 0;
      r = 0;
      repeat (n)
      begin
         @(negedge clock);
         f |= (fifo_flush === 1'b1);
         r |= (sweep_restart === 1'b1);
      end
   endtask : watch

   // --------------------
   // test sequence
   // --------------------
   initial
   begin
      repeat (20) @(negedge clock);
      reset = 1'b0;
      `CHK("cfg reset", `CPC_CFG_RESET, configuration_register)
      `CHK("ref reset", 4'b1100,
           {ref_on, ref_int, ref_4v, powered_down})
      wcfg(12'h400);
      `CHK("ref 4v", 2'b11, {ref_int, ref_4v})
      wcfg(12'h800);
      `CHK("ref ext", 2'b00, {ref_int, ref_4v})
      // oscillator conversions over clamp corners, last in two's complement
      for (int i = 0; i < 4; i++)
      begin
         if (i == 3)
            wcfg(12'h840);
         sample_code = (i == 0) ? upper_code : lower_code + 14'(i * 5 - 5);
         conv(0);
         `CHK("ring cycles", `CPC_CONV_CLOCKS * `CPC_RING_PERIOD_CYC,
              cyc)
         `CHK("result", (i == 0) ? `CPC_CODE_FULL :
              (i == 3) ? 12'h80a : 12'(i * 5 - 5), result_code)
      end
      // serial clock divide ratios, then wake by each access pin
      for (int k = 0; k < 3; k++)
      begin
         enc = (k == 0) ? cpc_pkg::cpc_div_by1 :
               (k == 1) ? cpc_pkg::cpc_div_by2 : cpc_pkg::cpc_div_by4;
         wcfg({3'b101, enc, 7'h00});
         conv(1 << k);
         `CHK("sclk rises", 14 * (1 << k), rises)
         u_cpc_host_model.access(k, 1'b1);
         repeat (3) @(negedge clock);
         `CHK("wake", 1'b1, ana_on)
         u_cpc_host_model.access(k, 1'b0);
      end
      // software power-down aborts a conversion
      cmd(16'h8001);
      `CHK("other word", 1'b0, powered_down)
      conv_request = 1'b1;
      repeat (5) @(negedge clock);
      conv_request = 1'b0;
      `CHK("busy", 1'b1, conv_busy)
      cmd(`CPC_SW_PD_CMD);
      `CHK("sw pd", 5'b11000, {powered_down, fifo_flush, ref_on, conv_busy,
           ana_on})
      wcfg(12'h0ff);
      `CHK("cfg kept", 12'hb00, configuration_register)
      u_cpc_host_model.access(1, 1'b1);
      watch(6);
      u_cpc_host_model.access(1, 1'b0);
      `CHK("sw wake", 3'b101, {r, powered_down, ref_on})
      // hardware power-down and release
      u_cpc_host_model.set_pd_pin(1'b0);
      #1;
      `CHK("hw off", 2'b00, {ana_on, ref_on})
      watch(6);
      `CHK("hw pd", 2'b11, {f, powered_down})
      u_cpc_host_model.set_pd_pin(1'b1);
      watch(6);
      `CHK("hw wake", 2'b10, {r, powered_down})
      `CHK("cfg after", 12'hb00, configuration_register)
      u_cpc_host_model.warm_up();
      give_verdict();
   end
endmodule : conversion_clock_power_control_tb

`default_nettype wire
